// [gpio_ports.sv]
// gpio_ports: five-port general purpose I/O with wake-up and supply select
// assumes pins, function selects and power state synchronous to mclk
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.svh"

module gpio_ports (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire gpio_pkg::gpio_pins_s pin_in,
  input  wire gpio_pkg::gpio_pins_s pull_capable,
  input  wire gpio_pkg::gpio_pins_s digital_func,
  input  wire logic [7:0]           porta_gpio_input,
  input  wire logic                 alt_supply_input_pin,
  input  wire logic                 low_power,
  input  wire logic                 wake_ack,
  output gpio_pkg::gpio_pins_s      pin_out,
  output gpio_pkg::gpio_pins_s      pin_oe,
  output gpio_pkg::gpio_pins_s      pullup_en,
  output logic      [7:0]           porta_alt_supply,
  output logic                      portc0_alt_supply,
  output logic      [7:0]           source_current_select_0,
  output logic      [7:0]           source_current_select_1,
  output logic      [3:0]           source_current_select_2,
  output logic                      wake_req,
  output logic                      irq
);
  import gpio_pkg::*;

  localparam int NP = `PORT_COUNT;

  logic [7:0]      latch    [NP];
  logic [7:0]      drive    [NP];
  logic [7:0]      pull     [NP];
  logic [7:0]      pull_eff [NP];
  logic [7:0]      live     [NP];
  logic [4:0][7:0] pin_v;
  logic [4:0][7:0] cap_v;
  logic [7:0]      wake_en;
  logic [7:0]      wake_arm;
  logic [7:0]      wake_event;
  logic [7:0]      irq_status;
  logic [7:0]      irq_mask;
  logic [7:0]      next_rdata;
  logic [7:0]      rd_mask;
  logic [5:0]      supply_sel;
  bus_state_e      bus_state;
  logic [2:0]      port_idx;
  logic [1:0]      reg_idx;
  logic            port_hit;
  logic            wr_en;
  logic            data_wr;

  assign pin_v    = pin_in;
  assign cap_v    = pull_capable;
  assign port_idx = avs_address[`PORT_IDX_MSB:`PORT_IDX_LSB];
  assign reg_idx  = avs_address[`REG_IDX_MSB:`REG_IDX_LSB];
  assign port_hit = !avs_address[7] && (avs_address[1:0] == 2'h0)
                    && (port_idx < 3'(NP));
  assign rd_mask  = (port_idx == `PORT_E_IDX) ? `PORT_E_MASK : `PORT_MASK;
  // writes land on the edge where the master sees waitrequest low
  assign wr_en    = avs_write && (bus_state == BUS_ANSWER)
                    && avs_byteenable[0];
  assign data_wr  = wr_en && port_hit && (reg_idx == `REG_DATA);

  // same pin logic on every port
  for (genvar i = 0; i < NP; i++) begin : g_port
    localparam logic [7:0] MASK = (i == NP - 1) ? `PORT_E_MASK : `PORT_MASK;
    logic hit;
    assign hit = wr_en && port_hit && (port_idx == 3'(i));
    assign live[i] = (pin_v[i] & ~drive[i]) | (latch[i] & drive[i]);

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        latch[i] <= `RST_DATA & MASK;
      end else if (hit && reg_idx == `REG_DATA) begin
        // top bits of port E dropped
        latch[i] <= avs_writedata[7:0] & MASK;
      end
    end

    // stored as drive enable, one means output
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        drive[i] <= `RST_DRIVE;
      end else if (hit && reg_idx == `REG_DIR) begin
        drive[i] <= ~avs_writedata[7:0] & MASK;
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pull[i] <= `RST_PULL;
      end else if (hit && reg_idx == `REG_PULL) begin
        pull[i] <= avs_writedata[7:0] & MASK;
      end
    end

    // gated by the pin's shared function
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pull_eff[i] <= `RST_PULL;
      end else begin
        pull_eff[i] <= pull[i] & cap_v[i] & MASK;
      end
    end
  end

  assign pin_out   = {latch[4], latch[3], latch[2], latch[1], latch[0]};
  assign pin_oe    = {drive[4], drive[3], drive[2], drive[1], drive[0]};
  assign pullup_en = {pull_eff[4], pull_eff[3], pull_eff[2], pull_eff[1],
                      pull_eff[0]};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_en <= `RST_WAKE;
    end else if (wr_en && port_hit && port_idx == 3'h0
                 && reg_idx == `REG_WAKE) begin
      wake_en <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      supply_sel <= `RST_SUPPLY;
    end else if (wr_en && avs_address == `OFF_SUPPLY) begin
      supply_sel <= avs_writedata[5:0];
    end
  end

  // four-level drive strength per pin group
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      source_current_select_0 <= `RST_SRC;
      source_current_select_1 <= `RST_SRC;
      source_current_select_2 <= `RST_SRC2;
    end else if (wr_en && avs_address == `OFF_SRC0) begin
      source_current_select_0 <= avs_writedata[7:0];
    end else if (wr_en && avs_address == `OFF_SRC1) begin
      source_current_select_1 <= avs_writedata[7:0];
    end else if (wr_en && avs_address == `OFF_SRC2) begin
      source_current_select_2 <= avs_writedata[3:0];
    end
  end

  // upper field to A7..A4, lower field to A3 and A1
  // only with port B pin 6 as supply input
  // only for digital in or out functions
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      porta_alt_supply  <= 8'h00;
      portc0_alt_supply <= 1'b0;
    end else begin
      porta_alt_supply  <= {{4{supply_sel[`SUP_UPA_BIT]}},
                            supply_sel[`SUP_LPA_BIT], 1'b0,
                            supply_sel[`SUP_LPA_BIT], 1'b0}
                           & {8{alt_supply_input_pin}} & digital_func.a;
      portc0_alt_supply <= supply_sel[`SUP_PC0_BIT] & alt_supply_input_pin
                           & digital_func.c[0];
    end
  end

  // armed only as general input pin
  assign wake_arm = wake_en & porta_gpio_input & ~drive[0];

  wake_detect u_wake (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pin       (pin_in.a),
    .arm       (wake_arm),
    .low_power (low_power),
    .fall      (wake_event)
  );

  // level held until acknowledged, new event wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else if (wake_event != 8'h00) begin
      wake_req <= 1'b1;
    end else if (wake_ack) begin
      wake_req <= 1'b0;
    end
  end

  // sticky per-pin wake status, write one to clear, set beats clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `RST_IRQ;
    end else if (wr_en && avs_address == `OFF_IRQ_STATUS) begin
      irq_status <= (irq_status & ~avs_writedata[7:0]) | wake_event;
    end else begin
      irq_status <= irq_status | wake_event;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `RST_IRQ;
    end else if (wr_en && avs_address == `OFF_IRQ_MASK) begin
      irq_mask <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // pins sampled during the request cycle itself
  always_comb begin
    next_rdata = 8'h00;
    if (port_hit && reg_idx == `REG_DATA) begin
      next_rdata = live[port_idx] & rd_mask;
    end else if (port_hit && reg_idx == `REG_DIR) begin
      next_rdata = ~drive[port_idx] & rd_mask;
    end else if (port_hit && reg_idx == `REG_PULL) begin
      next_rdata = pull[port_idx];
    end else if (port_hit && reg_idx == `REG_WAKE && port_idx == 3'h0) begin
      next_rdata = wake_en;
    end else if (avs_address == `OFF_SUPPLY) begin
      next_rdata = {2'b00, supply_sel};
    end else if (avs_address == `OFF_SRC0) begin
      next_rdata = source_current_select_0;
    end else if (avs_address == `OFF_SRC1) begin
      next_rdata = source_current_select_1;
    end else if (avs_address == `OFF_SRC2) begin
      next_rdata = {4'h0, source_current_select_2};
    end else if (avs_address == `OFF_IRQ_STATUS) begin
      next_rdata = irq_status;
    end else if (avs_address == `OFF_IRQ_MASK) begin
      next_rdata = irq_mask;
    end
  end

  // one wait cycle per access; unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state       <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state       <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h00_0000, next_rdata};
          end
        end
        default: begin
          bus_state       <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence bus_req;
    bus_state == BUS_IDLE && (avs_read || avs_write);
  endsequence

  sequence pa0_read;
    bus_state == BUS_IDLE && avs_read && port_hit && port_idx == 3'h0
      && reg_idx == `REG_DATA;
  endsequence

  sequence pa0_fall;
    low_power && (wake_arm & pin_in.a) != 8'h00
      ##1 low_power && (wake_arm & $past(pin_in.a) & ~pin_in.a) != 8'h00;
  endsequence

  answer_once_a: assert property (
    bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not exactly one cycle after request");

  read_input_a: assert property (
    (pa0_read and (pin_oe.a == 8'h00))
      |=> avs_readdata[7:0] == $past(pin_in.a))
    else $error("input read did not return live pin level");

  read_latch_a: assert property (
    (pa0_read and (pin_oe.a == 8'hff))
      |=> avs_readdata[7:0] == pin_out.a)
    else $error("output read did not return latch");

  latch_write_a: assert property (
    (data_wr && port_idx == 3'h1)
      |=> pin_out.b == $past(avs_writedata[7:0]))
    else $error("port data write not latched");

  latch_hold_a: assert property (
    !data_wr |=> $stable(pin_out))
    else $error("output latch changed without a write");

  dir_write_a: assert property (
    (wr_en && port_hit && port_idx == 3'h2 && reg_idx == `REG_DIR)
      |=> pin_oe.c == ~$past(avs_writedata[7:0]))
    else $error("direction write wrong polarity");

  pull_gate_a: assert property (
    (pull_capable.d == 8'h00) |=> (pullup_en.d == 8'h00))
    else $error("pull-up on while pin function forbids it");

  wake_fall_a: assert property (
    pa0_fall |=> wake_req)
    else $error("falling edge on armed pin gave no wake-up");

  wake_awake_a: assert property (
    (!low_power && !wake_req) |=> !wake_req)
    else $error("wake-up raised outside low-power mode");

  wake_hold_a: assert property (
    (wake_req && !wake_ack) |=> wake_req)
    else $error("wake-up request dropped before acknowledge");

  supply_gate_a: assert property (
    !alt_supply_input_pin |=> !portc0_alt_supply && porta_alt_supply == 8'h00)
    else $error("alternate supply chosen without supply input pin");

  supply_c0_a: assert property (
    (alt_supply_input_pin && digital_func.c[0] && supply_sel[`SUP_PC0_BIT])
      |=> portc0_alt_supply)
    else $error("port C pin 0 not on alternate supply");

  porte_top_a: assert property (
    pin_out.e[7:6] == 2'b00 && pin_oe.e[7:6] == 2'b00
      && pullup_en.e[7:6] == 2'b00)
    else $error("port E unimplemented bits active");
endmodule
`default_nettype wire

// [gpio_regs.svh]
// gpio_regs.svh: register offsets, field positions and reset values
// assumes byte addresses on a 32-bit Avalon-MM slave, data in bits 7..0
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH
`define PORT_COUNT      5
`define PORT_E_IDX      3'h4
`define PORT_IDX_MSB    6
`define PORT_IDX_LSB    4
`define REG_IDX_MSB     3
`define REG_IDX_LSB     2
`define REG_DATA        2'h0
`define REG_DIR         2'h1
`define REG_PULL        2'h2
`define REG_WAKE        2'h3
`define OFF_SUPPLY      8'h50
`define OFF_SRC0        8'h54
`define OFF_SRC1        8'h58
`define OFF_SRC2        8'h5c
`define OFF_IRQ_STATUS  8'h60
`define OFF_IRQ_MASK    8'h64
`define RST_DATA        8'hff
`define RST_DRIVE       8'h00
`define RST_PULL        8'h00
`define RST_WAKE        8'h00
`define RST_SUPPLY      6'h00
`define RST_SRC         8'h00
`define RST_SRC2        4'h0
`define RST_IRQ         8'h00
`define PORT_MASK       8'hff
`define PORT_E_MASK     8'h3f
`define SUP_PC0_BIT     5
`define SUP_UPA_BIT     3
`define SUP_LPA_BIT     1
`endif

// [gpio_pkg.sv]
// gpio_pkg: types shared by the port block, the pin board and the bench
// assumes nothing of its surroundings
`default_nettype none
package gpio_pkg;
  typedef struct packed {
    logic [7:0] e;
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } gpio_pins_s;

  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_e;
endpackage
`default_nettype wire

// [wake_detect.sv]
// wake_detect: per-pin high-to-low detector for the port A wake-up
// assumes pins already synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module wake_detect (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] pin,
  input  wire logic [7:0] arm,
  input  wire logic       low_power,
  output logic      [7:0] fall
);
  logic [7:0] prev;

  for (genvar i = 0; i < 8; i++) begin : g_bit
    // reset low: a pin already low at release is no wake event
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        prev[i] <= 1'b0;
      end else begin
        prev[i] <= pin[i];
      end
    end
    assign fall[i] = low_power & arm[i] & prev[i] & ~pin[i];
  end

  fall_once_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (fall != 8'h00) |=> ((fall & $past(fall)) == 8'h00))
    else $error("wake event lasted more than one cycle");
endmodule
`default_nettype wire

// [pin_board.sv]
// pin_board: board side of the port pins, strong drivers, pull-ups, floats
// assumes gpio_pkg compiled first; external drive is commanded by the bench
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input  wire logic                 mclk,
  input  wire gpio_pkg::gpio_pins_s pin_out,
  input  wire gpio_pkg::gpio_pins_s pin_oe,
  input  wire gpio_pkg::gpio_pins_s pullup_en,
  input  wire logic [39:0]          ext_val,
  input  wire logic [39:0]          ext_drive,
  output gpio_pkg::gpio_pins_s      pin_in
);
  import gpio_pkg::*;
  // a floating line wanders, so a stale level never passes for a real one
  logic [39:0] drift = 40'h0;
  always_ff @(posedge mclk) begin
    drift <= ~drift;
  end
  // weak pull to high
  // strong board source wins over the pin driver
  assign pin_in = (ext_drive & ext_val)
    | (~ext_drive & pin_oe & pin_out)
    | (~ext_drive & ~pin_oe & pullup_en)
    | (~ext_drive & ~pin_oe & ~pullup_en & drift);
endmodule
`default_nettype wire

// [tb_top.sv]
// tb_top: self-checking bench for gpio_ports against a register model
// assumes gpio_regs.svh, gpio_pkg, gpio_ports and pin_board alongside
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.svh"
module tb_top;
  import gpio_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wait_rq;
  gpio_pins_s  pin_in, pin_out, pin_oe, pullup_en;
  logic [39:0] pull_cap = 40'h0;
  logic [39:0] dig_func = 40'h0;
  logic [39:0] ext_val = 40'h0;
  logic [39:0] ext_drive = 40'hff_ffff_ffff;
  logic [7:0]  gpio_sel = 8'h00;
  logic        alt_in = 1'b0;
  logic        low_power = 1'b0;
  logic        wake_ack = 1'b0;
  logic [7:0]  alt_a, sc0, sc1;
  logic [3:0]  sc2;
  logic        alt_c0, wake_req, irq;
  int          n_fail = 0;
  int          check_count = 0;
  int          n, wb;
  logic [7:0]  lat [5], dir [5], pul [5], src [3], v, m;
  logic [31:0] q;
  logic [3:0]  be = 4'h1;
  logic [39:0] e_out, e_oe, e_pu;

  always #5 mclk = ~mclk;

  gpio_ports u_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_rq),
    .pin_in(pin_in), .pull_capable(pull_cap), .digital_func(dig_func),
    .porta_gpio_input(gpio_sel), .alt_supply_input_pin(alt_in),
    .low_power(low_power), .wake_ack(wake_ack), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .porta_alt_supply(alt_a),
    .portc0_alt_supply(alt_c0), .source_current_select_0(sc0),
    .source_current_select_1(sc1), .source_current_select_2(sc2),
    .wake_req(wake_req), .irq(irq));

  pin_board u_board (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_val(ext_val), .ext_drive(ext_drive),
    .pin_in(pin_in));

  function automatic logic [7:0] mk(input int p);
    return (p == 4) ? 8'h3f : 8'hff;
  endfunction

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge mclk);
    adr   <= a;
    wr_en <= w;
    rd_en <= ~w;
    wdat  <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wait_rq !== 1'b0 && n < 20);
    q = rdat;
    if (n >= 20) chk("waitrequest", 40'h0, 40'h1);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {32'h0, e}, {8'h0, q});
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    end_sim();
  end

  initial begin
    void'($urandom(4));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    ext_val <= 40'({$urandom, $urandom});
    @(posedge mclk);
    chk("oe_rst", 40'h0, pin_oe);
    chk("pu_rst", 40'h0, pullup_en);
    for (int p = 0; p < 5; p++) begin
      rc("dir_rst", 8'(p * 16 + 4), mk(p));
      rc("pull_rst", 8'(p * 16 + 8), 8'h00);
    end
    rc("wake_rst", 8'h0c, 8'h00);
    rc("sup_rst", `OFF_SUPPLY, 8'h00);
    done("reset");
    // two rounds of random latch, direction and board levels
    repeat (2) begin
      for (int p = 0; p < 5; p++) begin
        v = 8'($urandom);
        lat[p] = v & mk(p);
        wr(8'(p * 16), v);
        v = 8'($urandom);
        dir[p] = v & mk(p);
        wr(8'(p * 16 + 4), v);
        ext_val[p * 8 +: 8] <= 8'($urandom);
        @(posedge mclk);
        m = (dir[p] & ext_val[p * 8 +: 8] | ~dir[p] & lat[p]) & mk(p);
        rc("data", 8'(p * 16), m);
        rc("dir", 8'(p * 16 + 4), dir[p]);
        e_out[p * 8 +: 8] = lat[p];
        e_oe[p * 8 +: 8] = ~dir[p] & mk(p);
      end
      repeat (2) @(posedge mclk);
      chk("pin_out", e_out, pin_out);
      chk("pin_oe", e_oe, pin_oe);
    end
    done("io");
    pull_cap <= 40'({$urandom, $urandom});
    for (int p = 0; p < 5; p++) begin
      v = 8'($urandom);
      pul[p] = v & mk(p);
      wr(8'(p * 16 + 8), v);
      rc("pull", 8'(p * 16 + 8), pul[p]);
      e_pu[p * 8 +: 8] = pul[p];
    end
    repeat (3) @(posedge mclk);
    chk("pullup_en", e_pu & pull_cap, pullup_en);
    // board lets go of port A: enabled pull-ups must lift the input pins
    pull_cap[7:0] <= 8'hff;
    wr(8'h04, 8'hff);
    wr(8'h08, 8'hff);
    ext_drive[7:0] <= 8'h00;
    repeat (2) @(posedge mclk);
    rc("pull_pin", 8'h00, 8'hff);
    ext_drive[7:0] <= 8'hff;
    done("pull");
    for (int k = 0; k < 4; k++) begin
      alt_in <= k[0];
      dig_func <= 40'({$urandom, $urandom});
      v = k[1] ? 8'($urandom | 8'h2a) : 8'($urandom & 8'hd5);
      wr(`OFF_SUPPLY, v);
      rc("supply", `OFF_SUPPLY, v & 8'h3f);
      repeat (3) @(posedge mclk);
      m = {{4{v[3]}}, v[1], 1'b0, v[1], 1'b0} & {8{k[0]}};
      chk("alt_a", {32'h0, m & dig_func[7:0]}, {32'h0, alt_a});
      chk("alt_c0", {39'h0, v[5] & k[0] & dig_func[16]}, {39'h0, alt_c0});
    end
    done("supply");
    for (int k = 0; k < 3; k++) begin
      src[k] = (k == 2) ? 8'($urandom & 8'h0f) : 8'($urandom);
      wr(8'(`OFF_SRC0 + k * 4), src[k] | ((k == 2) ? 8'hf0 : 8'h00));
      rc("src", 8'(`OFF_SRC0 + k * 4), src[k]);
    end
    repeat (2) @(posedge mclk);
    chk("src_out", {16'h0, src[2], src[1], src[0]}, {20'h0, sc2, sc1, sc0});
    wr(8'h70, 8'h5a);
    rc("unmapped", 8'h70, 8'h00);
    rc("b_wake", 8'h1c, 8'h00);
    be <= 4'he;
    wr(`OFF_SRC0, ~src[0]);
    be <= 4'h1;
    rc("be_off", `OFF_SRC0, src[0]);
    done("source");
    wr(8'h04, 8'h00);
    rc("a_out", 8'h00, lat[0]);
    wb = $urandom_range(7, 0);
    m = 8'(1 << wb);
    wr(8'h04, 8'hff);
    wr(8'h0c, m);
    wr(`OFF_IRQ_MASK, m);
    rc("wake_en", 8'h0c, m);
    gpio_sel <= 8'hff;
    ext_val[7:0] <= 8'hff;
    repeat (2) @(posedge mclk);
    ext_val[wb] <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("wake_run", 40'h0, {39'h0, wake_req});
    rc("stat_run", `OFF_IRQ_STATUS, 8'h00);
    ext_val[wb] <= 1'b1;
    low_power <= 1'b1;
    repeat (2) @(posedge mclk);
    ext_val[wb] <= 1'b0;
    n = 0;
    while (wake_req !== 1'b1 && n < 5) begin
      @(posedge mclk);
      n++;
    end
    chk("wake_req", 40'h1, {39'h0, wake_req});
    repeat (3) @(posedge mclk);
    chk("wake_hold", 40'h1, {39'h0, wake_req});
    chk("irq", 40'h1, {39'h0, irq});
    rc("status", `OFF_IRQ_STATUS, m);
    wake_ack <= 1'b1;
    @(posedge mclk);
    wake_ack <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("wake_clr", 40'h0, {39'h0, wake_req});
    wr(`OFF_IRQ_STATUS, m);
    rc("stat_clr", `OFF_IRQ_STATUS, 8'h00);
    repeat (2) @(posedge mclk);
    chk("irq_clr", 40'h0, {39'h0, irq});
    done("wake");
    end_sim();
  end
endmodule
`default_nettype wire
